// [inc/scc_defs.svh]
// Offsets, field positions, reset values and timing for the serial port control block.
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
`define SCC_ADDR_W      12
`define SCC_CTRL_IDX    10'h0F3
`define SCC_STAT_IDX    10'h0F4
`define SCC_DATA_IDX    10'h0F5
`define SCC_CTRL_RST    8'h00
`define SCC_BIT_SELECT_OUTPUT_AUTO_DRIVE    7
`define SCC_BIT_EN      6
`define SCC_BIT_LSBF    5
`define SCC_BIT_CTRLR   4
`define SCC_BIT_CLOCK_IDLE_POLARITY    3
`define SCC_BIT_CLOCK_SAMPLE_PHASE    2
`define SCC_STAT_BUSY   0
`define SCC_STAT_DISMF  3
`define SCC_STAT_MODF   4
`define SCC_LAST_EDGE   4'hF
`define SCC_HALF_MAX    3'h7
`endif

// [inc/scc_pkg.sv]
// Types shared by the serial port control block.
package scc_pkg;
  typedef enum logic [0:0] {SCC_IDLE, SCC_XFER} scc_state_t;
  typedef logic [1:0] scc_rate_t;
endpackage

// [rtl/scc_top.sv]
// Serial port control register, select-pin logic and byte shifter behind APB.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.svh"
module scc_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`SCC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    serial_clock_pin_in,
  output logic                         serial_clock_pin_out,
  output logic                         serial_clock_pin_oe,
  input  wire logic                    mosi_in,
  output logic                         mosi_out,
  output logic                         mosi_oe,
  input  wire logic                    miso_in,
  output logic                         miso_out,
  output logic                         miso_oe,
  input  wire logic                    select_in_n,
  output logic                         select_out_n,
  output logic                         select_oe,
  output logic                         select_gpio_mode,
  output logic                         busy,
  output scc_pkg::scc_rate_t           rate_code
);
  import scc_pkg::*;

  logic [7:0] ctrl_q;
  logic       mode_fault_detect_disable_q;
  logic       modf_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] rxbuf_q;
  logic [3:0] edge_cnt_q;
  logic [2:0] div_q;
  logic       sclk_q;
  logic       sclk_in_q;
  scc_state_t state_q;

  logic en, ctrlr, lsbf, clock_idle_polarity, clock_sample_phase, select_output_auto_drive;
  assign select_output_auto_drive  = ctrl_q[`SCC_BIT_SELECT_OUTPUT_AUTO_DRIVE];
  assign en    = ctrl_q[`SCC_BIT_EN];
  assign lsbf  = ctrl_q[`SCC_BIT_LSBF];
  assign ctrlr = ctrl_q[`SCC_BIT_CTRLR];
  assign clock_idle_polarity  = ctrl_q[`SCC_BIT_CLOCK_IDLE_POLARITY];
  assign clock_sample_phase  = ctrl_q[`SCC_BIT_CLOCK_SAMPLE_PHASE];

  // APB decode: registers sit at four times their index.
  logic       acc;
  logic       wr;
  logic [9:0] idx;
  logic       hit;
  assign idx = paddr[`SCC_ADDR_W-1:2];
  assign hit = (paddr[1:0] == 2'b00) &&
               (idx == `SCC_CTRL_IDX || idx == `SCC_STAT_IDX || idx == `SCC_DATA_IDX);
  assign acc = psel && penable && pready;
  assign wr  = acc && pwrite && hit;

  // Every access completes in its first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (paddr[1:0] == 2'b00) begin
        case (idx)
          `SCC_CTRL_IDX: prdata[7:0] <= ctrl_q;
          `SCC_STAT_IDX: begin
            prdata[`SCC_STAT_MODF]  <= modf_q;
            prdata[`SCC_STAT_DISMF] <= mode_fault_detect_disable_q;
            prdata[`SCC_STAT_BUSY]  <= (state_q == SCC_XFER);
          end
          `SCC_DATA_IDX: prdata[7:0] <= rxbuf_q;
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `SCC_CTRL_RST;
    end else if (wr && idx == `SCC_CTRL_IDX) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  // Fault detection only counts while the port is an enabled controller.
  logic fault_watch;
  logic fault_ev;
  assign fault_watch = en && ctrlr && !mode_fault_detect_disable_q;
  assign fault_ev    = fault_watch && !select_in_n;

  // The fault flag is cleared by writing 0; a fault in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_fault_detect_disable_q <= 1'b0;
      modf_q    <= 1'b0;
    end else begin
      if (wr && idx == `SCC_STAT_IDX) begin
        mode_fault_detect_disable_q <= pwdata[`SCC_STAT_DISMF];
        modf_q    <= pwdata[`SCC_STAT_MODF] && modf_q;
      end
      if (fault_ev) begin
        modf_q <= 1'b1;
      end
    end
  end

  // Edge detection for both roles.
  logic half_tick;
  logic edge_ev;
  logic new_lvl;
  logic lead;
  logic sample;
  logic tgt_act;
  logic [2:0] half_cnt;
  // Half a serial period is 1, 2, 4 or 8 system clocks.
  assign half_cnt  = 3'((4'h1 << ctrl_q[1:0]) - 4'h1);
  assign half_tick = (div_q == half_cnt);
  assign tgt_act   = en && !ctrlr && !select_in_n;
  always_comb begin
    edge_ev = 1'b0;
    new_lvl = clock_idle_polarity;
    if (ctrlr) begin
      edge_ev = (state_q == SCC_XFER) && half_tick;
      new_lvl = !sclk_q;
    end else if (tgt_act) begin
      // Remote clock is sampled directly, so it must stay below half pclk.
      edge_ev = (serial_clock_pin_in != sclk_in_q);
      new_lvl = serial_clock_pin_in;
    end
  end
  assign lead   = (new_lvl != clock_idle_polarity);
  assign sample = lead ^ clock_sample_phase;

  logic start;
  // Busy trails the state by a cycle; waiting for it keeps the select high
  // for at least one idle cycle between two bytes.
  assign start = wr && idx == `SCC_DATA_IDX && en && ctrlr &&
                 state_q == SCC_IDLE && !fault_ev && !busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_in_q <= 1'b0;
    end else begin
      sclk_in_q <= serial_clock_pin_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SCC_IDLE;
    end else begin
      case (state_q)
        SCC_IDLE: begin
          if (start || (tgt_act && edge_ev)) begin
            state_q <= SCC_XFER;
          end
        end
        SCC_XFER: begin
          if (!en || fault_ev || (!ctrlr && select_in_n) ||
              (edge_ev && edge_cnt_q == `SCC_LAST_EDGE)) begin
            state_q <= SCC_IDLE;
          end
        end
        default: state_q <= SCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 3'h0;
    end else if (state_q != SCC_XFER || half_tick || !ctrlr) begin
      div_q <= 3'h0;
    end else if (div_q != `SCC_HALF_MAX) begin
      div_q <= div_q + 3'h1;
    end
  end

  // The controller clock returns to its idle level whenever no byte moves.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
    end else if (state_q != SCC_XFER || !ctrlr) begin
      sclk_q <= clock_idle_polarity;
    end else if (edge_ev) begin
      sclk_q <= new_lvl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt_q <= 4'h0;
    end else if (state_q == SCC_IDLE && !(tgt_act && edge_ev)) begin
      edge_cnt_q <= 4'h0;
    end else if (edge_ev) begin
      edge_cnt_q <= edge_cnt_q + 4'h1;
    end
  end

  // Shift-out happens on the non-sampling edges; the very first edge never
  // shifts, because the first bit is already on the line before it.
  logic shift_out;
  logic in_bit;
  assign shift_out = edge_ev && !sample && (edge_cnt_q != 4'h0 || state_q == SCC_XFER && clock_sample_phase == 1'b0);
  assign in_bit    = ctrlr ? miso_in : mosi_in;

  // The pins are registered, so a controller clock edge reaches the line one
  // cycle after it is made; capture waits that cycle so the reply has settled.
  // A target sees the remote edge late already and captures at once.
  logic       cap_q;
  logic       last_q;
  logic       cap_now;
  logic       last_now;
  logic       last_edge;
  logic [7:0] rx_next;
  assign last_edge = edge_ev && edge_cnt_q == `SCC_LAST_EDGE && state_q == SCC_XFER;
  assign cap_now   = ctrlr ? cap_q : (edge_ev && sample);
  assign last_now  = ctrlr ? last_q : last_edge;
  assign rx_next   = lsbf ? {in_bit, rx_q[7:1]} : {rx_q[6:0], in_bit};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q  <= 1'b0;
      last_q <= 1'b0;
    end else begin
      cap_q  <= ctrlr && edge_ev && sample;
      last_q <= ctrlr && last_edge;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= 8'h00;
    end else if (wr && idx == `SCC_DATA_IDX && state_q == SCC_IDLE && !busy) begin
      tx_q <= pwdata[7:0];
    end else if (shift_out && edge_cnt_q != 4'h0) begin
      tx_q <= lsbf ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= 8'h00;
    end else if (cap_now) begin
      rx_q <= rx_next;
    end
  end

  // On the last edge the byte is complete only if that edge also samples.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_q <= 8'h00;
    end else if (last_now) begin
      rxbuf_q <= cap_now ? rx_next : rx_q;
    end
  end

  // Pin drive. Disabled ports release every pin.
  logic out_bit;
  logic xfer;
  assign out_bit = lsbf ? tx_q[0] : tx_q[7];
  assign xfer    = (state_q == SCC_XFER);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe  <= 1'b0;
      mosi_out             <= 1'b0;
      mosi_oe              <= 1'b0;
      miso_out             <= 1'b0;
      miso_oe              <= 1'b0;
    end else begin
      serial_clock_pin_out <= ctrlr ? sclk_q : clock_idle_polarity;
      serial_clock_pin_oe  <= en && ctrlr;
      mosi_out             <= out_bit;
      mosi_oe              <= en && ctrlr;
      miso_out             <= out_bit;
      miso_oe              <= en && !ctrlr && !select_in_n;
    end
  end

  // Select pin: only an enabled controller with fault detection off and
  // auto-drive on drives it; otherwise it is an input or plain I/O.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_out_n     <= 1'b1;
      select_oe        <= 1'b0;
      select_gpio_mode <= 1'b1;
    end else begin
      // Held one cycle past the byte so the last clock edge reaches the line first.
      select_out_n     <= !((xfer || busy) && ctrlr);
      select_oe        <= en && ctrlr && mode_fault_detect_disable_q && select_output_auto_drive;
      select_gpio_mode <= !en || (ctrlr && mode_fault_detect_disable_q && !select_output_auto_drive);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy      <= 1'b0;
      rate_code <= 2'b00;
    end else begin
      busy      <= xfer;
      rate_code <= ctrl_q[1:0];
    end
  end
endmodule // scc_top
`default_nettype wire

// [bench/scc_top_monitor.sv]
// Port-level assertion checker for the serial port control block.
`timescale 1ns/1ps
`default_nettype none
module scc_mon (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               serial_clock_pin_out,
  input wire logic               serial_clock_pin_oe,
  input wire logic               mosi_oe,
  input wire logic               miso_oe,
  input wire logic               select_out_n,
  input wire logic               select_oe,
  input wire logic               select_gpio_mode,
  input wire logic               busy,
  input wire scc_pkg::scc_rate_t rate_code
);
  import scc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] run_q;
  logic [4:0] edges_q;
  logic       seen_q;
  // A half period is timed only between two toggles of one byte, never from idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 5'd0;
      seen_q <= 1'b0;
    end else begin
      run_q <= $changed(serial_clock_pin_out) ? 5'd1 : run_q + 5'd1;
      seen_q <= busy && ($changed(serial_clock_pin_out) || seen_q);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      edges_q <= 5'd0;
    else if (select_out_n && $past(select_out_n))
      edges_q <= 5'd0;
    else
      edges_q <= edges_q + {4'd0, $changed(serial_clock_pin_out)};
  end
  chk_sel_idle_high: assert property ((!busy)[*3] ##0 select_oe |-> select_out_n)
    else $error("select low while idle");
  chk_sel_low_xfer: assert property ($rose(busy) && select_oe |-> !select_out_n)
    else $error("select high during transfer");
  chk_pin_excl: assert property (select_oe |-> !select_gpio_mode)
    else $error("select pin both driven and plain");
  chk_role_excl: assert property (!(serial_clock_pin_oe && miso_oe))
    else $error("both roles drive");
  chk_ctrl_mosi: assert property (serial_clock_pin_oe == mosi_oe)
    else $error("controller enables disagree");
  chk_half_period: assert property ($changed(serial_clock_pin_out) && seen_q
    |-> run_q == (5'd1 << rate_code))
    else $error("serial clock half period wrong");
  chk_edge_count: assert property ($rose(select_out_n) |=> edges_q == 5'd16)
    else $error("edge count per byte wrong");
  chk_reset_vals: assert property ($rose(presetn)
    |-> rate_code == 2'b00 && select_gpio_mode && !serial_clock_pin_oe)
    else $error("outputs not cleared by reset");
  cover property ($rose(busy));
  cover property ($rose(busy) && rate_code == 2'b11);
  cover property (select_gpio_mode ##1 select_oe);
endmodule // scc_mon
bind scc_top scc_mon u_scc_mon (.pclk, .presetn, .serial_clock_pin_out, .serial_clock_pin_oe,
  .mosi_oe, .miso_oe, .select_out_n, .select_oe, .select_gpio_mode, .busy, .rate_code);
`default_nettype wire

// [bench/scc_target_model.sv]
// Behavioural remote target that swaps one byte per select frame.
`timescale 1ns/1ps
`default_nettype none
module scc_tgt (
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic       clock_idle_polarity,
  input  wire logic       clock_sample_phase,
  input  wire logic       lsb_first,
  input  wire logic [7:0] tx_byte,
  output var  logic       miso,
  output var  logic [7:0] rx_byte
);
  int idx;
  function automatic logic pick(input int i);
    return lsb_first ? tx_byte[i] : tx_byte[7-i];
  endfunction
  initial miso = 1'b0;
  always @(negedge sel_n) begin
    idx = 0;
    miso = pick(0);
  end
  // Released, the line shows the inverse of its last bit so a stale sample cannot match.
  always @(posedge sel_n) miso = ~miso;
  always @(sclk) begin
    if (!sel_n && (sclk ^ clock_idle_polarity ^ clock_sample_phase)) begin
      rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      idx++;
    end else if (!sel_n && idx < 8) begin
      miso = pick(idx);
    end
  end
endmodule // scc_tgt
`default_nettype wire

// [bench/scc_top_tb.sv]
// Self-checking testbench for the serial port control block.
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.svh"
module scc_top_tb;
  import scc_pkg::*;
  localparam logic [11:0] CTRL_A = {`SCC_CTRL_IDX, 2'b00};
  localparam logic [11:0] STAT_A = {`SCC_STAT_IDX, 2'b00};
  localparam logic [11:0] DATA_A = {`SCC_DATA_IDX, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe, sel_n, sel_oe, gpio, busy;
  logic        clock_idle_polarity, clock_sample_phase, lsb, sel_in_n;
  logic [7:0]  tx, rx;
  scc_rate_t   rate;
  int          num_errors, checked;
  scc_top u_scc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serial_clock_pin_in(1'b0), .serial_clock_pin_out(sclk),
    .serial_clock_pin_oe(sclk_oe), .mosi_in(1'b0), .mosi_out(mosi), .mosi_oe,
    .miso_in(miso), .miso_out(), .miso_oe, .select_in_n(sel_in_n), .select_out_n(sel_n),
    .select_oe(sel_oe), .select_gpio_mode(gpio), .busy, .rate_code(rate));
  scc_tgt u_scc_tgt (.sclk, .sel_n, .mosi, .clock_idle_polarity, .clock_sample_phase, .lsb_first(lsb), .tx_byte(tx),
    .miso, .rx_byte(rx));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 3000) begin
      @(negedge pclk);
      n++;
    end
    if (busy !== v) begin
      num_errors++;
      print_verdict();
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, clock_idle_polarity, clock_sample_phase, lsb, tx} = '0;
    sel_in_n = 1'b1;
    num_errors = 0;
    checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({gpio, sclk_oe, sel_oe}, 3'b100);
    apb(0, CTRL_A, 8'h00);
    chk(rd, 8'h00);
    apb(0, 12'h000, 8'h00);
    chk(err, 1'b1);
    apb(1, CTRL_A, 8'hFF);
    apb(0, CTRL_A, 8'h00);
    chk(rd, 8'hFF);
    apb(1, STAT_A, 8'h08);
    for (int m = 0; m < 8; m++) begin
      clock_idle_polarity = m[0];
      clock_sample_phase = m[1];
      lsb = m[2];
      tx = 8'h3C ^ m[7:0];
      apb(1, CTRL_A, {24'h00_0000, 2'b11, lsb, 1'b1, clock_idle_polarity, clock_sample_phase, m[1:0]});
      repeat (3) @(negedge pclk);
      chk(sclk, clock_idle_polarity);
      chk(rate, m[1:0]);
      chk({sel_oe, gpio, sclk_oe}, 3'b101);
      apb(1, DATA_A, 32'h5A ^ m);
      wait_busy(1'b1);
      wait_busy(1'b0);
      chk(rx, 32'h5A ^ m);
      apb(0, DATA_A, 8'h00);
      chk(rd, tx);
      chk(sclk, clock_idle_polarity);
    end
    apb(1, CTRL_A, 8'h50);
    repeat (2) @(negedge pclk);
    chk({sel_oe, gpio}, 2'b01);
    apb(1, STAT_A, 8'h00);
    apb(1, CTRL_A, 8'hD0);
    repeat (2) @(negedge pclk);
    chk({sel_oe, gpio}, 2'b00);
    @(posedge pclk);
    sel_in_n <= 1'b0;
    apb(0, STAT_A, 8'h00);
    sel_in_n <= 1'b1;
    chk(rd, 32'h0000_0010);
    apb(1, STAT_A, 8'h00);
    apb(0, STAT_A, 8'h00);
    chk(rd, 32'h0000_0000);
    apb(1, CTRL_A, 8'hC0);
    repeat (2) @(negedge pclk);
    chk({sclk_oe, mosi_oe, miso_oe, sel_oe}, 4'h0);
    apb(1, CTRL_A, 8'h90);
    apb(1, DATA_A, 8'h66);
    repeat (4) @(negedge pclk);
    chk({sclk_oe, mosi_oe, busy, gpio}, 4'h1);
    apb(1, CTRL_A, 8'hFF);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, CTRL_A, 8'h00);
    chk(rd, 8'h00);
    print_verdict();
  end
endmodule // scc_top_tb
`default_nettype wire
